// File: logic/vrc_reference_control.v
`timescale 1ns/10ps
`include "vrc_consts.vh"
module vrc_reference_control
(
  sys_clk,
  reset_n,
  sfr_page,
  sfr_addr,
  sfr_wr,
  sfr_rd,
  sfr_wdata,
  sfr_rdata,
  sfr_hit,
  conv_active,
  sampling_active,
  temp_sampling,
  ref_sel_onehot,
  gnd_from_pin,
  hs_ref_power,
  temp_sensor_power,
  prec_ref_power
);
  input  wire       sys_clk;           // System clock, 20 MHz
  input  wire       reset_n;           // Synchronous reset, active low
  input  wire [3:0] sfr_page;          // Current register page
  input  wire [7:0] sfr_addr;          // Register address
  input  wire       sfr_wr;            // Write strobe, one cycle
  input  wire       sfr_rd;            // Read strobe
  input  wire [7:0] sfr_wdata;         // Write data
  output reg  [7:0] sfr_rdata;         // Read data, zero when not selected
  output wire       sfr_hit;           // Address matches this register
  input  wire       conv_active;       // Converter conversion period
  input  wire       sampling_active;   // Converter sampling period
  input  wire       temp_sampling;     // Sensor channel selected for sampling
  output wire [3:0] ref_sel_onehot;    // Reference source switches
  output wire       gnd_from_pin;      // Ground taken from analog ground pin
  output wire       hs_ref_power;      // High-speed reference power
  output wire       temp_sensor_power; // Temperature sensor power
  output wire       prec_ref_power;    // Precision reference on and on pin

  reg  [7:0] voltage_reference_control; // Stored register image
  wire [7:0] reg_view;                  // Image as software sees it

  // Decode the register's page and address
  assign sfr_hit = (sfr_page == `VRC_SFR_PAGE) && (sfr_addr == `VRC_SFR_ADDR);

  // Unused bits never hold storage, so they always read zero
  assign reg_view = voltage_reference_control & `VRC_WRITE_MASK;

  // Register write; only writable bits are kept
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      voltage_reference_control <= `VRC_RESET_VALUE;
    end
    else if (sfr_wr && sfr_hit)
    begin
      voltage_reference_control <= sfr_wdata & `VRC_WRITE_MASK;
    end
  end

  // Registered read data; unrelated addresses read zero
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sfr_rdata <= 8'h00;
    end
    else if (sfr_rd && sfr_hit)
    begin
      sfr_rdata <= reg_view;
    end
    else
    begin
      sfr_rdata <= 8'h00;
    end
  end

  // Multiplexer control stage
  vrc_ground_mux_ctrl u_mux
  (
    .sys_clk                     (sys_clk),
    .reset_n                     (reset_n),
    .reference_source_select     (voltage_reference_control[`VRC_BIT_SRC_HI:`VRC_BIT_SRC_LO]),
    .analog_ground_select        (voltage_reference_control[`VRC_BIT_GND_SEL]),
    .temp_sensor_enable          (voltage_reference_control[`VRC_BIT_TEMP_EN]),
    .precision_ref_output_enable (voltage_reference_control[`VRC_BIT_PREC_EN]),
    .conv_active                 (conv_active),
    .temp_sampling               (temp_sampling),
    .sampling_active             (sampling_active),
    .ref_sel_onehot              (ref_sel_onehot),
    .gnd_from_pin                (gnd_from_pin),
    .hs_ref_power                (hs_ref_power),
    .temp_sensor_power           (temp_sensor_power),
    .prec_ref_power              (prec_ref_power)
  );
endmodule // vrc_reference_control

// File: logic/vrc_consts.vh
`ifndef VRC_CONSTS_VH
`define VRC_CONSTS_VH
// Special function register placement
`define VRC_SFR_PAGE        4'h0
`define VRC_SFR_ADDR        8'hd1
// Field positions inside the control register
`define VRC_BIT_GND_SEL     5
`define VRC_BIT_SRC_HI      4
`define VRC_BIT_SRC_LO      3
`define VRC_BIT_TEMP_EN     2
`define VRC_BIT_PREC_EN     0
// Mask of the bits that hold storage
`define VRC_WRITE_MASK      8'h3d
// Reset value of the whole register
`define VRC_RESET_VALUE     8'h18
// Source switches after reset: code 11 closes the high-speed switch
`define VRC_ONEHOT_RESET    4'h8
// Reference source codes
`define VRC_SRC_EXT_PIN     2'h0
`define VRC_SRC_MAIN_SUPPLY 2'h1
`define VRC_SRC_DIG_SUPPLY  2'h2
`define VRC_SRC_HS_REF      2'h3
`endif

// File: logic/vrc_ground_mux_ctrl.v
`timescale 1ns/10ps
// Own include, so the file does not depend on compile order
`include "vrc_consts.vh"
// Works out the analog multiplexer controls from the stored selections
module vrc_ground_mux_ctrl
(
  sys_clk,
  reset_n,
  reference_source_select,
  analog_ground_select,
  temp_sensor_enable,
  precision_ref_output_enable,
  conv_active,
  temp_sampling,
  sampling_active,
  ref_sel_onehot,
  gnd_from_pin,
  hs_ref_power,
  temp_sensor_power,
  prec_ref_power
);
  input  wire       sys_clk;                     // System clock
  input  wire       reset_n;                     // Synchronous reset, active low
  input  wire [1:0] reference_source_select;     // Stored source code
  input  wire       analog_ground_select;        // Stored ground choice
  input  wire       temp_sensor_enable;          // Stored sensor enable
  input  wire       precision_ref_output_enable; // Stored precision enable
  input  wire       conv_active;                 // Converter in conversion period
  input  wire       temp_sampling;               // Sensor channel being sampled
  input  wire       sampling_active;             // Converter in sampling period
  output reg  [3:0] ref_sel_onehot;              // One switch per reference source
  output reg        gnd_from_pin;                // High routes ground from analog pin
  output reg        hs_ref_power;                // High-speed reference supply on
  output reg        temp_sensor_power;           // Sensor powered, else high impedance
  output reg        prec_ref_power;              // Precision ref on and tied to pin

  // Decode source code to one-hot switch controls
  function [3:0] vrc_decode;
    input [1:0] code;
    begin
      vrc_decode = 4'h1 << code;
    end
  endfunction

  reg [3:0] next_ref_sel;   // Source switches for the next cycle
  reg       next_gnd_pin;   // Ground routing for the next cycle
  reg       hs_selected;    // High-speed reference is the chosen source

  // Combine selections with converter activity
  always @*
  begin
    next_ref_sel = vrc_decode(reference_source_select);
    hs_selected  = (reference_source_select == `VRC_SRC_HS_REF);
    next_gnd_pin = analog_ground_select;
    // Sensor sampling always uses chip ground
    if (temp_sampling && sampling_active)
    begin
      next_gnd_pin = 1'b0;
    end
    // High-speed reference forces chip ground while converting
    if (hs_selected && conv_active)
    begin
      next_gnd_pin = 1'b0;
    end
  end

  // Registered outputs so the analog switches see clean levels
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      ref_sel_onehot    <= `VRC_ONEHOT_RESET;
      gnd_from_pin      <= 1'b0;
      hs_ref_power      <= 1'b0;
      temp_sensor_power <= 1'b0;
      prec_ref_power    <= 1'b0;
    end
    else
    begin
      ref_sel_onehot    <= next_ref_sel;
      gnd_from_pin      <= next_gnd_pin;
      // Powered only while the converter needs it; saves idle current
      hs_ref_power      <= hs_selected & (conv_active | sampling_active);
      temp_sensor_power <= temp_sensor_enable;
      prec_ref_power    <= precision_ref_output_enable;
    end
  end
endmodule // vrc_ground_mux_ctrl

// File: tb/vrc_checker.sv
`timescale 1ns/10ps
// Port-level checks of the reference control block
module vrc_checker (input logic sys_clk, reset_n, sfr_wr, sfr_rd, sfr_hit,
  conv_active, sampling_active, temp_sampling, gnd_from_pin, hs_ref_power,
  temp_sensor_power, prec_ref_power, input logic [3:0] sfr_page, ref_sel_onehot,
  input logic [7:0] sfr_addr, sfr_wdata, sfr_rdata);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire w = sfr_wr & sfr_hit; // Write accepted this cycle
  property p_hit; sfr_hit == (sfr_page == 4'h0 && sfr_addr == 8'hd1); endproperty
  a_hit: assert property (p_hit) else $error("bad decode");
  property p_rsv; sfr_rd && sfr_hit |=> (sfr_rdata & 8'hc2) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("unused bits set");
  property p_idle; !(sfr_rd && sfr_hit) |=> sfr_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_src; w |-> ##2 ref_sel_onehot == 4'h1 << $past(sfr_wdata[4:3], 2); endproperty
  a_src: assert property (p_src) else $error("source wrong");
  property p_en;
    w |-> ##2 {temp_sensor_power, prec_ref_power} == {$past(sfr_wdata[2], 2),
      $past(sfr_wdata[0], 2)};
  endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_tgnd; temp_sampling && sampling_active |=> !gnd_from_pin; endproperty
  a_tgnd: assert property (p_tgnd) else $error("sensor ground");
  // Skip the cycle after a write: the onehot still shows the old code
  property p_hgnd; ref_sel_onehot[3] && conv_active && !$past(w) |=> !gnd_from_pin; endproperty
  a_hgnd: assert property (p_hgnd) else $error("fast ref ground");
  property p_hs;
    !$past(w) |=> hs_ref_power == $past(ref_sel_onehot[3] && (conv_active || sampling_active));
  endproperty
  a_hs: assert property (p_hs) else $error("fast ref power");
  property p_rst; $rose(reset_n) |-> ref_sel_onehot == 4'h8 && !prec_ref_power; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // vrc_checker
bind vrc_reference_control vrc_checker u_chk (.*);

// File: tb/vrc_conv_model.sv
`timescale 1ns/10ps
// Converter stand-in: three sampling cycles, then four converting
module vrc_conv_model (input logic sys_clk, start, temp_ch,
  output logic sampling_active, conv_active, temp_sampling);
  int cnt = 0;                 // Cycles left in the frame
  initial temp_sampling = 1'b0;
  // A start inside a frame is ignored, as a busy converter would
  always @(posedge sys_clk)
  begin
    if (cnt == 0 && start) cnt <= 7;
    else if (cnt != 0) cnt <= cnt - 1;
    if (cnt == 0) temp_sampling <= start & temp_ch;
  end
  assign sampling_active = cnt > 4;
  assign conv_active = cnt > 0 && cnt < 5;
endmodule // vrc_conv_model

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic sys_clk = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0, start = 0, temp_ch = 0;
  logic [3:0] sfr_page = 0, ref_sel_onehot, e_oh;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, e_rd, m;
  logic sfr_hit, conv_active, sampling_active, temp_sampling, gnd_from_pin;
  logic hs_ref_power, temp_sensor_power, prec_ref_power, e_gp, e_hs, e_tp, e_pp;
  int bad_count = 0, tests_run = 0, cyc = 0;
  logic [7:0] tv [6] = '{8'h00, 8'h01, 8'hff, 8'h3b, 8'hc2, 8'h38}; // Edge values
  wire mh = sfr_page == 4'h0 && sfr_addr == 8'hd1; // Own address decode
  always #25 sys_clk = ~sys_clk;
  vrc_reference_control i_vrc_reference_control (.*);
  vrc_conv_model i_vrc_conv_model (.*);
  // Bench model: outputs follow the stored byte and inputs one edge late
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (!reset_n) begin m <= 8'h18; e_oh <= 4'h8; {e_gp, e_hs, e_tp, e_pp, e_rd} <= 0; end
    else
    begin
      e_oh <= 4'h1 << m[4:3];
      e_gp <= m[5] && !(temp_sampling && sampling_active) && !(m[4:3] == 3 && conv_active);
      e_hs <= m[4:3] == 3 && (conv_active || sampling_active);
      e_tp <= m[2];
      e_pp <= m[0];
      e_rd <= (sfr_rd && mh) ? m : 8'h00;
      if (sfr_wr && mh) m <= sfr_wdata & 8'h3d; // Unused bits never stored
    end
    if (cyc == 2000) begin bad_count++; finish_test; end // Hang guard
  end
  task automatic chk(input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin bad_count++; $display("CHECK FAILED %0t got %h exp %h", $time, s, e); end
  endtask
  // Compare on the falling edge, where everything has settled
  always @(negedge sys_clk) if (cyc > 0)
  begin
    chk(ref_sel_onehot, e_oh);
    chk(gnd_from_pin, e_gp);
    chk(hs_ref_power, e_hs);
    chk(temp_sensor_power, e_tp);
    chk(prec_ref_power, e_pp);
    chk(sfr_rdata, e_rd);
    chk(sfr_hit, mh);
  end
  // One bus cycle: 0 idle, 1 write, 2 read; converter starts at random
  task automatic drv(input int op, input logic [3:0] p, input logic [7:0] a, d);
    sfr_wr = op == 1;
    sfr_rd = op == 2;
    sfr_page = p;
    sfr_addr = a;
    sfr_wdata = d;
    start = $urandom % 4 == 0;
    temp_ch = $urandom % 2;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(21827));
    repeat (12) @(posedge sys_clk);
    #1 reset_n = 1;
    drv(2, 4'h0, 8'hd1, 8'h00);
    // External and precision setups first, then all-ones and unused-only
    // The clock source never changes here, so enabling the precision reference is safe
    foreach (tv[i])
    begin
      drv(1, 4'h0, 8'hd1, tv[i]);
      drv(2, 4'h0, 8'hd1, 8'h00);
    end
    // Random traffic, with page 1 and a neighbouring address mixed in
    repeat (400) drv($urandom % 3, 4'($urandom % 8 == 0), ($urandom % 8) ? 8'hd1 : 8'hd2,
      8'($urandom));
    drv(0, 4'h0, 8'h00, 8'h00);
    finish_test;
  end
endmodule // tb_top
